// ==== core/cas_serial_port.sv ====
// serial audio port core: apb registers, frame timing, shifters
// assumes an apb master on pclk and a bench resolving the pins
//
// Implementation choice: the APB slave port.
`timescale 1ns/100ps
`default_nettype none
`include "cas_consts.svh"
////////////////////////////////////////////////////////////////////////
// Overview of operation
// [R01] clock output follows codec clock without inversion
// [R02] clock register bit 7 selects codec clock or codec clock halved
// [R03] clock output held low during reset
// [R04] halved clock output toggles only on master clock rising edges
// [R05] software prefers halved clock output and powers unused buffer down
// [R06] four formats, 16 to 32 bit words, no 32 bits right justified
// [R07] every word goes out and comes in msb first
// [R08] adc samples serialised on data out, channel shown by adc align
// [R09] dac samples taken from data in, channel shown by dac align
// [R10] data and align clocks change on bit clock falling edges
// [R11] align clocks change only on bit clock falling edges
// [R12] bit and align clocks driven in master mode, inputs in slave
// [R13] left justified: msb valid first rising edge after align edge
// [R14] i2s: msb valid second rising edge after align edge
// [R15] right justified: lsb valid at rising edge before align edge; code places it by the previous half's length
// [R16] frame sync: left msb first or second rise, right follows
// [R17] frame sync allows idle bit clocks after the right lsb
// [R18] external master may drive non 50:50 align clocks
// [R19] external bit clock may pause but carries enough cycles
// [R20] master normal: 50:50 align clocks, bit clock 64x sample rate
// [R21] master usb: bit clock equals codec clock, align 187:188
// [R22] software keeps the format fixed while running
// [R23] format field: 11 frame, 10 i2s, 01 left, 00 right
// [R24] word length field: 32, 24, 20, 16 bits; shared by directions
// [R25] bit 6 set selects master mode, clear selects slave
// [R26] right justified with 32 bit setting falls back to 24 bits
// [R27] master clocks all derive from the codec clock
module cas_serial_port #(
   parameter int BCLK_HALF = 2
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // clock pin
   output logic buffered_clock_output,
   // bit clock pin
   input wire logic serial_bit_clock_in,
   output logic serial_bit_clock_out,
   output logic serial_bit_clock_oe,
   // align clock pins
   input wire logic adc_channel_align_clock_in,
   output logic adc_channel_align_clock_out,
   output logic adc_channel_align_clock_oe,
   input wire logic dac_channel_align_clock_in,
   output logic dac_channel_align_clock_out,
   output logic dac_channel_align_clock_oe,
   // data pins
   output logic adc_serial_out,
   input wire logic dac_serial_in,
   // user side samples
   input wire logic [23:0] adc_left_sample,
   input wire logic [23:0] adc_right_sample,
   output logic [23:0] dac_left_sample,
   output logic [23:0] dac_right_sample,
   output logic dac_sample_valid
);
   logic [8:0] ifc_reg;
   logic [8:0] clk_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic [31:0] prdata_reg;
   cas_pkg::cas_fmt_type fmt;
   logic [1:0] wl;
   logic ph;
   logic ms;
   logic usb;
   logic [5:0] len;
   logic setup;
   logic wr;
   logic hit;
   logic [31:0] rd_data;
   logic codec_rise;
   logic codec_fall;
   logic [3:0] s1_reg;
   logic [3:0] s2_reg;
   logic [3:0] s3_reg;
   logic [3:0] f_reg;
   logic [3:0] f_next;
   logic [3:0] pin_in;
   logic m_bclk_reg;
   logic m_lrc_reg;
   logic [3:0] m_div_reg;
   logic [8:0] m_cnt_reg;
   logic oe_reg;
   logic m_wrap;
   logic m_bclk_next;
   logic m_fall;
   logic [8:0] m_lim;
   logic m_flip;
   logic m_lrc_next;
   logic ev_fall;
   logic ev_rise;
   logic [1:0] lrc_now;
   logic [1:0] restart;
   logic [1:0][7:0] slot;
   logic adc_out_reg;
   logic [23:0] hold_reg;
   logic [23:0] tx_src;
   logic tx_bit;
   logic [7:0] rx_slot_reg;
   logic [23:0] acc_reg;
   logic [23:0] rx_mask;
   logic [23:0] rx_word;
   logic [23:0] dacl_reg;
   logic [23:0] dacr_reg;
   logic dac_valid_reg;
   ////////////////////////////////////////////////////////////////////
   // control fields
   assign fmt = cas_pkg::cas_fmt_type'(ifc_reg[`CAS_FMT_LSB +: 2]); // [R23]
   assign wl = ifc_reg[`CAS_WL_LSB +: 2];
   assign ph = ifc_reg[`CAS_PH_BIT];
   assign ms = ifc_reg[`CAS_MS_BIT]; // [R25]
   assign usb = ifc_reg[`CAS_USB_BIT];
   // one length for both directions
   assign len = (wl == cas_pkg::wl_32) ?
      ((fmt == cas_pkg::fmt_rj) ? 6'h18 : 6'h20) : // [R26]
      (wl == cas_pkg::wl_24) ? 6'h18 :
      (wl == cas_pkg::wl_20) ? 6'h14 : 6'h10; // [R24] [R06]
   ////////////////////////////////////////////////////////////////////
   // apb slave, zero wait states, answer registered in the setup cycle
   assign setup = psel & ~penable & ~pready_reg;
   assign wr = psel & penable & pready_reg & pwrite;
   assign hit = (paddr == `CAS_OFS_IFC) | (paddr == `CAS_OFS_CLK) |
      (paddr == `CAS_OFS_STS) | (paddr == `CAS_OFS_DACL) |
      (paddr == `CAS_OFS_DACR);
   assign rd_data =
      (paddr == `CAS_OFS_IFC) ? {23'h000000, ifc_reg} :
      (paddr == `CAS_OFS_CLK) ? {23'h000000, clk_reg} :
      (paddr == `CAS_OFS_STS) ? {28'h0000000, restart == 2'b00,
         lrc_now[0], ms ? m_bclk_reg : f_reg[0], ms} :
      (paddr == `CAS_OFS_DACL) ? {8'h00, dacl_reg} :
      (paddr == `CAS_OFS_DACR) ? {8'h00, dacr_reg} : 32'h00000000;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg <= 32'h00000000;
      end else begin
         pready_reg <= setup;
         pslverr_reg <= setup & ~hit;
         if (setup) begin
            prdata_reg <= pwrite ? 32'h00000000 : rd_data;
         end
      end
   end
   // changing format while running is left to software
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ifc_reg <= `CAS_IFC_RST;
         clk_reg <= `CAS_CLK_RST;
      end else if (wr && paddr == `CAS_OFS_IFC) begin
         ifc_reg <= pwdata[8:0] & `CAS_IFC_MASK;
      end else if (wr && paddr == `CAS_OFS_CLK) begin
         clk_reg <= pwdata[8:0] & `CAS_CLK_MASK; // [R02]
      end
   end
   ////////////////////////////////////////////////////////////////////
   // codec clock and clock output
   cas_clk_out u_clk (
      .pclk(pclk),
      .presetn(presetn),
      .codec_half_sel(clk_reg[`CAS_CIDIV_BIT]),
      .clock_output_half_select(clk_reg[`CAS_CODIV_BIT]),
      .codec_rise(codec_rise),
      .codec_fall(codec_fall),
      .codec_level(),
      .buffered_clock_output(buffered_clock_output)
   ); // [R01]
   ////////////////////////////////////////////////////////////////////
   // pin inputs: 3 flops, a change counts when stages 2 and 3 agree
   assign pin_in = {dac_serial_in, dac_channel_align_clock_in,
      adc_channel_align_clock_in, serial_bit_clock_in};
   for (genvar g = 0; g < 4; g++) begin : g_filt
      assign f_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : f_reg[g];
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_reg <= 4'h0;
         s2_reg <= 4'h0;
         s3_reg <= 4'h0;
         f_reg <= 4'h0;
      end else begin
         s1_reg <= pin_in;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         f_reg <= f_next;
      end
   end
   ////////////////////////////////////////////////////////////////////
   // master timing from codec clock edges only
   assign m_wrap = m_div_reg == 4'(BCLK_HALF - 1);
   assign m_bclk_next = !ms ? 1'b0 :
      usb ? (codec_rise | (m_bclk_reg & ~codec_fall)) : // [R21]
      (m_bclk_reg ^ (codec_rise & m_wrap)); // [R27] [R20]
   assign m_fall = m_bclk_reg & ~m_bclk_next;
   assign m_lim = usb ?
      (m_lrc_reg ? `CAS_USB_HI - 9'h001 : `CAS_USB_LO - 9'h001) : // [R21]
      `CAS_HALF_BITS - 9'h001; // [R20]
   assign m_flip = m_fall & (m_cnt_reg == m_lim);
   // leaving master, align parks low only with a bit clock fall
   assign m_lrc_next = ms ? (m_lrc_reg ^ m_flip) : (m_lrc_reg & ~m_fall); // [R11]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         m_bclk_reg <= 1'b0;
         m_lrc_reg <= 1'b0;
         m_div_reg <= 4'h0;
         m_cnt_reg <= 9'h000;
         oe_reg <= 1'b0;
      end else begin
         m_bclk_reg <= m_bclk_next;
         m_lrc_reg <= m_lrc_next;
         m_div_reg <= (!ms || usb || (codec_rise && m_wrap)) ? 4'h0 :
            m_div_reg + {3'h0, codec_rise};
         m_cnt_reg <= (!ms || m_flip) ? 9'h000 :
            m_cnt_reg + {8'h00, m_fall};
         oe_reg <= ms; // [R12]
      end
   end
   assign serial_bit_clock_out = m_bclk_reg;
   assign adc_channel_align_clock_out = m_lrc_reg;
   assign dac_channel_align_clock_out = m_lrc_reg;
   assign serial_bit_clock_oe = oe_reg;
   assign adc_channel_align_clock_oe = oe_reg;
   assign dac_channel_align_clock_oe = oe_reg;
   ////////////////////////////////////////////////////////////////////
   // bit clock events; align levels are those after the edge
   assign ev_fall = ms ? m_fall : (f_reg[0] & ~f_next[0]); // [R10]
   assign ev_rise = ms ? (~m_bclk_reg & m_bclk_next) :
      (~f_reg[0] & f_next[0]);
   assign lrc_now = ms ? {m_lrc_next, m_lrc_next} : f_next[2:1];
   // slot of a fall: {valid, right, bit index from the msb}
   function automatic logic [7:0] word_slot(input logic [8:0] idx,
      input logic channel_align_clock, input logic [8:0] hl);
      logic [9:0] st;
      logic [9:0] p;
      logic rt;
      logic ok;
      st = 10'h000;
      rt = (channel_align_clock == ph);
      ok = 1'b1;
      unique case (fmt)
         cas_pkg::fmt_fs: begin
            rt = {1'b0, idx} >= ({9'h000, ph} + {4'h0, len}); // [R16]
            st = rt ? ({9'h000, ph} + {4'h0, len}) : {9'h000, ph};
         end
         cas_pkg::fmt_i2s: begin
            rt = (channel_align_clock != ph);
            st = 10'h001; // [R14]
         end
         cas_pkg::fmt_lj: begin
            st = 10'h000; // [R13]
         end
         cas_pkg::fmt_rj: begin
            // lsb lands on the last fall before the next align edge if this half is as long as the previous one
            st = {1'b0, hl} - {4'h0, len}; // [R15]
            ok = hl >= {3'h0, len};
         end
      endcase
      p = {1'b0, idx} - st;
      return {ok && p < {4'h0, len}, rt, p[5:0]}; // [R17]
   endfunction
   // one frame tracker per direction: lane 0 adc, lane 1 dac
   for (genvar l = 0; l < 2; l++) begin : g_lane
      logic last_reg;
      logic [8:0] cnt_reg;
      logic [8:0] hl_reg;
      logic trans;
      logic [8:0] idx;
      assign trans = lrc_now[l] ^ last_reg;
      assign restart[l] = (fmt == cas_pkg::fmt_fs) ?
         (trans & lrc_now[l]) : trans; // [R16]
      assign idx = restart[l] ? 9'h000 : cnt_reg;
      assign slot[l] = word_slot(idx, lrc_now[l], hl_reg);
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            last_reg <= 1'b0;
            cnt_reg <= 9'h000;
            hl_reg <= `CAS_HALF_BITS;
         end else if (ev_fall) begin
            last_reg <= lrc_now[l];
            cnt_reg <= restart[l] ? 9'h001 :
               (cnt_reg == `CAS_SAT_CNT) ? cnt_reg : cnt_reg + 9'h001;
            if (restart[l]) begin
               hl_reg <= cnt_reg;
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////
   // adc transmit, msb first, 24 bit source zero padded past bit 23
   assign tx_src = slot[0][6] ? adc_right_sample : adc_left_sample;
   assign tx_bit = !slot[0][7] ? 1'b0 :
      (slot[0][5:0] == 6'h00) ? tx_src[23] :
      (slot[0][5:0] < 6'h18) ? hold_reg[5'(6'h17 - slot[0][5:0])] :
      1'b0; // [R07] [R08]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         adc_out_reg <= 1'b0;
         hold_reg <= 24'h000000;
      end else if (ev_fall) begin
         adc_out_reg <= tx_bit; // [R10]
         if (slot[0][7] && slot[0][5:0] == 6'h00) begin
            hold_reg <= tx_src;
         end
      end
   end
   assign adc_serial_out = adc_out_reg;
   ////////////////////////////////////////////////////////////////////
   // dac receive: bits beyond 24 dropped, short words zero padded
   assign rx_mask = (rx_slot_reg[5:0] < 6'h18) ?
      (24'h800000 >> rx_slot_reg[4:0]) : 24'h000000;
   assign rx_word = (((rx_slot_reg[5:0] == 6'h00) ? 24'h000000 : acc_reg)
      & ~rx_mask) | (f_next[3] ? rx_mask : 24'h000000); // [R07]
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rx_slot_reg <= 8'h00;
         acc_reg <= 24'h000000;
         dacl_reg <= 24'h000000;
         dacr_reg <= 24'h000000;
         dac_valid_reg <= 1'b0;
      end else begin
         dac_valid_reg <= 1'b0;
         if (ev_fall) begin
            rx_slot_reg <= slot[1];
         end
         if (ev_rise && rx_slot_reg[7]) begin
            acc_reg <= rx_word;
            if (rx_slot_reg[5:0] == len - 6'h01) begin
               dac_valid_reg <= 1'b1; // [R09]
               if (rx_slot_reg[6]) begin
                  dacr_reg <= rx_word;
               end else begin
                  dacl_reg <= rx_word;
               end
            end
         end
      end
   end
   assign dac_left_sample = dacl_reg;
   assign dac_right_sample = dacr_reg;
   assign dac_sample_valid = dac_valid_reg;
   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_r12;
      serial_bit_clock_oe == $past(ms) && adc_channel_align_clock_oe
         == serial_bit_clock_oe;
   endproperty
   a_r12: assert property (p_r12) else $error("pin drive mode"); // [R12]
   property p_r11;
      $changed(adc_channel_align_clock_out)
         |-> $fell(serial_bit_clock_out);
   endproperty
   a_r11: assert property (p_r11) else $error("align off fall"); // [R11]
   property p_r10;
      $changed(adc_serial_out) |-> $past(ev_fall);
   endproperty
   a_r10: assert property (p_r10) else $error("data off fall"); // [R10]
   property p_r20;
      ms && !usb && $stable(ifc_reg) && $changed(m_lrc_reg)
         |-> $past(m_cnt_reg) == 9'h01f && $fell(m_bclk_reg);
   endproperty
   a_r20: assert property (p_r20) else $error("align half len"); // [R20]
   property p_r21;
      ms && usb && $stable(ifc_reg) && $fell(m_lrc_reg)
         |-> $past(m_cnt_reg) == 9'h0ba;
   endproperty
   a_r21: assert property (p_r21) else $error("usb high phase"); // [R21]
   property p_r26;
      fmt == cas_pkg::fmt_rj && wl == cas_pkg::wl_32 |-> len == 6'h18;
   endproperty
   a_r26: assert property (p_r26) else $error("rj 32 fallback"); // [R26]
   property p_r24;
      fmt != cas_pkg::fmt_rj |-> len == 6'h10 + {2'b00, wl, 2'b00}
         + {3'h0, wl == 2'b11, 2'b00};
   endproperty
   a_r24: assert property (p_r24) else $error("word length"); // [R24]
   sequence s_lj_start;
      fmt == cas_pkg::fmt_lj && ev_fall && restart[0];
   endsequence
   property p_r13;
      s_lj_start |=> adc_serial_out == $past(tx_src[23]);
   endproperty
   a_r13: assert property (p_r13) else $error("lj msb place"); // [R13]
   sequence s_i2s_second;
      fmt == cas_pkg::fmt_i2s && ev_fall && !restart[0]
         && g_lane[0].cnt_reg == 9'h001;
   endsequence
   property p_r14;
      s_i2s_second |-> slot[0][7] && slot[0][5:0] == 6'h00;
   endproperty
   a_r14: assert property (p_r14) else $error("i2s msb place"); // [R14]
endmodule
`default_nettype wire

// ==== shared/cas_consts.svh ====
// register offsets, field positions, reset values and frame counts
// included by bare name; definitions only
`ifndef CAS_CONSTS_SVH
`define CAS_CONSTS_SVH
`define CAS_OFS_IFC 12'h000
`define CAS_OFS_CLK 12'h008
`define CAS_OFS_STS 12'h00c
`define CAS_OFS_DACL 12'h010
`define CAS_OFS_DACR 12'h014
`define CAS_IFC_RST 9'h00a
`define CAS_IFC_MASK 9'h15f
`define CAS_CLK_RST 9'h000
`define CAS_CLK_MASK 9'h0c0
`define CAS_FMT_LSB 0
`define CAS_WL_LSB 2
`define CAS_PH_BIT 4
`define CAS_MS_BIT 6
`define CAS_USB_BIT 8
`define CAS_CIDIV_BIT 6
`define CAS_CODIV_BIT 7
`define CAS_HALF_BITS 9'h020
`define CAS_USB_HI 9'h0bb
`define CAS_USB_LO 9'h0bc
`define CAS_SAT_CNT 9'h1ff
`endif

// ==== shared/cas_pkg.sv ====
// types shared by the serial audio port core
// no constants here; numbers live in cas_consts.svh
package cas_pkg;
   typedef enum logic [1:0] {
      fmt_rj = 2'b00,
      fmt_lj = 2'b01,
      fmt_i2s = 2'b10,
      fmt_fs = 2'b11
   } cas_fmt_type;
   typedef enum logic [1:0] {
      wl_16 = 2'b00,
      wl_20 = 2'b01,
      wl_24 = 2'b10,
      wl_32 = 2'b11
   } cas_wl_type;
endpackage

// ==== core/cas_clk_out.sv ====
// codec clock and buffered clock output generator
// assumes pclk stands in for twice the master clock rate
`timescale 1ns/100ps
`default_nettype none
module cas_clk_out (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // selects
   input wire logic codec_half_sel,
   input wire logic clock_output_half_select,
   // codec clock events
   output logic codec_rise,
   output logic codec_fall,
   output logic codec_level,
   // pin
   output logic buffered_clock_output
);
   logic mclk_reg;
   logic codec_reg;
   logic clk_out_reg;
   logic codec_next;
   logic clk_out_next;
   ////////////////////////////////////////////////////////////////////
   assign codec_next = codec_half_sel ?
      (codec_reg ^ ~mclk_reg) : ~mclk_reg;
   assign codec_rise = ~codec_reg & codec_next;
   assign codec_fall = codec_reg & ~codec_next;
   assign codec_level = codec_reg;
   // halved output steps only on a codec rise, itself a master rise
   assign clk_out_next = clock_output_half_select ?
      (clk_out_reg ^ codec_rise) : codec_next; // [R02] [R04]
   assign buffered_clock_output = clk_out_reg;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mclk_reg <= 1'b0;
         codec_reg <= 1'b0;
         clk_out_reg <= 1'b0; // [R03]
      end else begin
         mclk_reg <= ~mclk_reg;
         codec_reg <= codec_next;
         clk_out_reg <= clk_out_next; // [R01]
      end
   end
   ////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_r01;
      !clock_output_half_select && $past(!clock_output_half_select)
         |-> buffered_clock_output == codec_reg;
   endproperty
   a_r01: assert property (p_r01) else $error("clock out phase"); // [R01]
   property p_r03;
      $past(!presetn) |-> !buffered_clock_output;
   endproperty
   a_r03: assert property (p_r03) else $error("clock out in reset"); // [R03]
   property p_r04;
      clock_output_half_select && $past(clock_output_half_select)
         && $changed(buffered_clock_output) |-> $rose(mclk_reg);
   endproperty
   a_r04: assert property (p_r04) else $error("half clock edge"); // [R04]
endmodule
`default_nettype wire

// ==== verif/cas_host_model.sv ====
// host side serial audio port model: clocks, align clock, dac data
// assumes the bench resolves each pin from the device output enables
`timescale 1ns/100ps
`default_nettype none
module cas_host_model #(
   parameter int HALF = 8,
   parameter int LO = 33,
   parameter int HI = 40,
   parameter logic [31:0] DL = 32'h0,
   parameter logic [31:0] DR = 32'h0
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // setup
   input wire logic run,
   input wire logic [1:0] fmt,
   input wire logic [5:0] nbits,
   // pins
   input wire logic bclk_w,
   input wire logic lrc_w,
   input wire logic adc_w,
   output logic h_bclk,
   output logic h_lrc,
   output logic h_dac,
   // seen words {left, right} and half lengths {high, low}
   output logic [63:0] caps,
   output logic [17:0] lens
);
   logic [3:0] dv;
   logic [8:0] gs, s;
   logic b_q, l_q;
   logic [31:0] cap;
   wire i2s = (fmt == cas_pkg::fmt_i2s);
   wire [8:0] off = (fmt == cas_pkg::fmt_rj) ? 9'(32 - nbits)
      : {8'h00, fmt != cas_pkg::fmt_lj};
   wire edge_l = (lrc_w != l_q);
   wire [8:0] sn = edge_l ? 9'h000 : s + 9'h001;
   wire [8:0] kn = sn - off;
   wire [8:0] k = s - off;
   wire [31:0] word = (i2s ? lrc_w : ~lrc_w) ? DR : DL;
   wire rt_o = i2s ? l_q : ~l_q;
   wire [8:0] glen = h_lrc ? 9'(HI - 1) : 9'(LO - 1);
   wire tick = (dv == 4'(HALF - 1));
   ////////////////////////////////////////
   // clock stands still between runs; halves are unequal on purpose
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dv <= 4'h0;
         gs <= 9'h000;
         h_bclk <= 1'b0;
         h_lrc <= 1'b0;
      end else if (run) begin
         dv <= tick ? 4'h0 : dv + 4'h1;
         if (tick) begin
            h_bclk <= ~h_bclk;
            if (h_bclk) begin
               gs <= (gs == glen) ? 9'h000 : gs + 9'h001;
               if (gs == glen) h_lrc <= ~h_lrc;
            end
         end
      end
   end
   // unused slots carry a changing pattern, never the last bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         b_q <= 1'b0;
         l_q <= 1'b0;
         s <= 9'h000;
         cap <= 32'h0;
         h_dac <= 1'b0;
         caps <= 64'h0;
         lens <= 18'h0;
      end else begin
         b_q <= bclk_w;
         if (b_q && !bclk_w) begin
            l_q <= lrc_w;
            s <= sn;
            h_dac <= (kn < 9'(nbits)) ?
               word[5'(31 - kn)] : sn[0];
            if (edge_l) begin
               cap <= 32'h0;
               if (rt_o) caps[31:0] <= cap;
               else caps[63:32] <= cap;
               if (l_q) lens[17:9] <= s + 9'h001;
               else lens[8:0] <= s + 9'h001;
            end
         end else if (!b_q && bclk_w && k < 9'(nbits)) begin
            cap[5'(31 - k)] <= adc_w;
         end
      end
   end
endmodule
`default_nettype wire

// ==== verif/cas_serial_port_tb.sv ====
// bench: apb rows, clock output rates, audio frames in lj, i2s and rj formats
// assumes cas_host_model on the serial pins, pins resolved here
`timescale 1ns/100ps
`default_nettype none
module cas_serial_port_tb;
   typedef struct packed {
      logic w;
      logic [11:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic er;
   } cas_row_type;
   localparam logic [23:0] AL = 24'hc35a96;
   localparam logic [23:0] AR = 24'h5ac3e1;
   localparam logic [31:0] DL = 32'h9a3c5e71;
   localparam logic [31:0] DR = 32'h6d18c4b2;
   localparam logic [7:0] CK [4] = '{8'h00, 8'h80, 8'h40, 8'hc0};
   localparam int NR [4] = '{20, 10, 10, 5};
   localparam logic [5:0] NB [4] = '{6'd16, 6'd20, 6'd24, 6'd32};
   cas_row_type rows [11] = '{
      '{1'b0, 12'h000, 32'h0, 32'h00a, 1'b0},
      '{1'b0, 12'h008, 32'h0, 32'h000, 1'b0},
      '{1'b0, 12'h00c, 32'h0, 32'h008, 1'b0},
      '{1'b1, 12'h008, 32'h1ff, 32'h0, 1'b0},
      '{1'b0, 12'h008, 32'h0, 32'h0c0, 1'b0},
      '{1'b1, 12'h014, 32'hffffffff, 32'h0, 1'b0},
      '{1'b0, 12'h014, 32'h0, 32'h000, 1'b0},
      '{1'b1, 12'h040, 32'h1, 32'h0, 1'b1},
      '{1'b0, 12'h040, 32'h0, 32'h000, 1'b1},
      '{1'b1, 12'h000, 32'hffffffff, 32'h0, 1'b0},
      '{1'b0, 12'h000, 32'h0, 32'h15f, 1'b0}};
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, run = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [1:0] fmt = 2'b10;
   logic [5:0] nb = 6'd24;
   logic [31:0] prdata, rd, m;
   logic pready, pslverr, er, bco, bk_o, bk_oe, al_o, al_oe, dl_o, dl_oe;
   logic adc_d, h_bk, h_lr, h_dac, vld;
   logic [23:0] dls, drs;
   logic [63:0] caps;
   logic [17:0] lens;
   int n_mismatch = 0, cmp_count = 0, nv = 0, nrise = 0, nr;
   wire bk_w = bk_oe ? bk_o : h_bk;
   wire al_w = al_oe ? al_o : h_lr;
   wire dl_w = dl_oe ? dl_o : h_lr;
   ////////////////////////////////////////
   cas_serial_port #(.BCLK_HALF(4)) uut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .buffered_clock_output(bco),
      .serial_bit_clock_in(bk_w), .serial_bit_clock_out(bk_o),
      .serial_bit_clock_oe(bk_oe), .adc_channel_align_clock_in(al_w),
      .adc_channel_align_clock_out(al_o),
      .adc_channel_align_clock_oe(al_oe), .dac_channel_align_clock_in(dl_w),
      .dac_channel_align_clock_out(dl_o),
      .dac_channel_align_clock_oe(dl_oe), .adc_serial_out(adc_d),
      .dac_serial_in(h_dac), .adc_left_sample(AL), .adc_right_sample(AR),
      .dac_left_sample(dls), .dac_right_sample(drs),
      .dac_sample_valid(vld));
   cas_host_model #(.DL(DL), .DR(DR)) host (
      .pclk(pclk), .presetn(presetn), .run(run), .fmt(fmt), .nbits(nb),
      .bclk_w(bk_w), .lrc_w(dl_w), .adc_w(adc_d), .h_bclk(h_bk),
      .h_lrc(h_lr), .h_dac(h_dac), .caps(caps), .lens(lens));
   always #5 pclk = ~pclk;
   always @(posedge pclk) if (vld === 1'b1) nv++;
   always @(posedge bco) nrise++;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      cmp_count++;
      if (g !== e) begin
         n_mismatch++;
         $display("ERROR %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [11:0] a,
         input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 16) n_mismatch++;
   endtask
   // host clocks stop before the format moves, then frames settle
   task automatic audio(input logic [8:0] cfg, input logic [5:0] bits);
      run <= 1'b0;
      repeat (300) @(posedge pclk);
      apb(1'b1, 12'h000, {23'h0, cfg});
      fmt <= cfg[1:0];
      nb <= bits;
      run <= ~cfg[6];
      nr = nv;
      repeat (3600) @(posedge pclk);
      m = ~(32'hffffffff >> bits);
      chk(caps[63:32], {AL, 8'h00} & m);
      chk(caps[31:0], {AR, 8'h00} & m);
      chk({8'h0, dls}, (DL & m) >> 8);
      chk({8'h0, drs}, (DR & m) >> 8);
      chk({30'h0, nv > nr, bk_oe}, {30'h0, 1'b1, cfg[6]});
   endtask
   task automatic report_and_stop;
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   // about 41k cycles expected; the limit leaves some slack
   initial begin
      #600000;
      n_mismatch++;
      report_and_stop;
   end
   initial begin
      repeat (2) @(posedge pclk);
      chk({31'h0, bco}, 32'h0);
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      foreach (rows[i]) begin
         apb(rows[i].w, rows[i].a, rows[i].d);
         chk({31'h0, er}, {31'h0, rows[i].er});
         if (!rows[i].w) chk(rd, rows[i].e);
      end
      foreach (CK[i]) begin
         apb(1'b1, 12'h008, {24'h0, CK[i]});
         repeat (9) @(posedge pclk);
         nr = nrise;
         repeat (40) @(posedge pclk);
         chk(32'(nrise - nr), 32'(NR[i]));
      end
      apb(1'b1, 12'h008, 32'h0);
      for (int f = 1; f < 3; f++) begin
         foreach (NB[w]) audio({5'h00, 2'(w), 2'(f)}, NB[w]);
      end
      audio(9'h04a, 6'd24);
      chk({14'h0, lens}, {14'h0, 9'd32, 9'd32});
      audio(9'h04c, 6'd24);
      apb(1'b1, 12'h000, 32'h14a);
      repeat (2000) @(posedge pclk);
      chk({14'h0, lens}, {14'h0, 9'd187, 9'd188});
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      chk({30'h0, bco, bk_oe}, 32'h0);
      presetn <= 1'b1;
      apb(1'b0, 12'h000, 32'h0);
      chk(rd, 32'h00a);
      report_and_stop;
   end
endmodule
`default_nettype wire
